/* logic/vcsr_regs.sv */
// vc0 resource status and vc1 resource capability registers
// assumes config reads/writes and table events arrive on mclk;
// negotiation and refresh-done levels come from other logic via sync
`include "vcsr_defines.svh"

module vcsr_regs
  import vcsr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              cfg_rd,
  input  wire logic              cfg_wr,
  input  wire logic [ADDR_W-1:0] cfg_addr,
  input  wire logic [31:0]       cfg_wdata,
  input  wire logic              negotiation_in_progress,
  input  wire logic              arb_table_write,
  input  wire logic              table_load_req,
  input  wire logic              refresh_done,
  output logic      [31:0]       cfg_rdata,
  output logic                   cfg_rvalid,
  output logic                   refresh_start
);

  initial begin
    if (ADDR_W < 9) $error("vcsr_regs: ADDR_W too narrow for 16Ch");
  end

  // ----------------------------------------------------------------
  // synchronised external levels
  // ----------------------------------------------------------------
  logic [1:0] ext_s;

  vcsr_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .din  ({refresh_done, negotiation_in_progress}),
    .dout (ext_s)
  );

  // ----------------------------------------------------------------
  // table dirty tracking
  // ----------------------------------------------------------------
  vcsr_tbl_state_t tbl_r;
  vcsr_tbl_state_t tbl_nxt;
  logic            pend_r;
  logic            pend_nxt;
  logic            start_nxt;

  always_comb begin
    tbl_nxt   = tbl_r;
    start_nxt = 1'b0;
    pend_nxt  = ext_s[0];
    case (tbl_r)
      VCSR_CLEAN: begin
        if (arb_table_write) tbl_nxt = VCSR_DIRTY;
      end
      VCSR_DIRTY: begin
        if (table_load_req) begin
          tbl_nxt   = VCSR_LOADING;
          start_nxt = 1'b1;
        end
      end
      VCSR_LOADING: begin
        // an edit during the refresh keeps the table dirty
        if (arb_table_write) tbl_nxt = VCSR_DIRTY;
        else if (ext_s[1]) tbl_nxt = VCSR_CLEAN;
      end
      default: tbl_nxt = VCSR_CLEAN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tbl_r         <= VCSR_CLEAN;
      pend_r        <= 1'b0;
      refresh_start <= 1'b0;
    end else if (ce) begin
      tbl_r         <= tbl_nxt;
      pend_r        <= pend_nxt;
      refresh_start <= start_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [15:0] status_val;
  logic [31:0] cap_val;
  logic [31:0] rdata_nxt;
  logic        rvalid_nxt;

  always_comb begin
    status_val = `VCSR_ST_RESET;
    status_val[`VCSR_ST_PEND_BIT]  = pend_r;
    status_val[`VCSR_ST_DIRTY_BIT] = (tbl_r != VCSR_CLEAN);
    // bit 23 and 15:8 zero; 7:0 one bit per scheme
    cap_val = {`VCSR_CAP_TBL_LOC, 1'b0, `VCSR_CAP_SLOTS,
               1'b0, 1'b0, 6'h00, `VCSR_CAP_SCHEMES};
    rvalid_nxt = cfg_rd;
    rdata_nxt  = 32'h00000000;
    if (cfg_rd) begin
      // 16Ah is a half-word in the upper lane of dword 168h
      if (cfg_addr == ADDR_W'(`VCSR_OFF_VC0_STATUS)) begin
        rdata_nxt = {16'h0000, status_val};
      end else if (cfg_addr == ADDR_W'(`VCSR_OFF_VC1_CAP)) begin
        rdata_nxt = cap_val;
      end
    end
  end

  // writes are decoded nowhere: nothing here is writable
  logic unused_wr;
  assign unused_wr = cfg_wr ^ (^cfg_wdata);

  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rdata  <= rdata_nxt;
      cfg_rvalid <= rvalid_nxt;
    end
  end

endmodule

/* logic/vcsr_sync.sv */
// two-stage synchroniser for levels arriving from outside mclk
// assumes the caller samples only dout
module vcsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  initial begin
    if (WIDTH < 1) $error("vcsr_sync: WIDTH must be at least 1");
  end

  always_comb begin
    meta_nxt = ce ? din : meta_r;
    dout_nxt = ce ? meta_r : dout;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end
endmodule

/* shared/vcsr_defines.svh */
// vc status/capability register slice: offsets, fields, reset values
// assumes extended config space byte offsets, no other bus
`ifndef VCSR_DEFINES_SVH
`define VCSR_DEFINES_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define VCSR_OFF_VC0_STATUS 12'h16A
`define VCSR_OFF_VC1_CAP    12'h16C

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define VCSR_ST_DIRTY_BIT   0
`define VCSR_ST_PEND_BIT    1
`define VCSR_ST_RESET       16'h0000

// ----------------------------------------------------------------
// capability fields
// ----------------------------------------------------------------
`define VCSR_CAP_TBL_LOC    8'h07
`define VCSR_CAP_SLOTS      7'h7F
`define VCSR_CAP_SCHEMES    8'h11
`define VCSR_CAP_RESET      32'h077F0011

`endif

/* shared/vcsr_pkg.sv */
// vc status/capability types
// assumes vcsr_defines.svh is on the include path
package vcsr_pkg;
  typedef enum logic [1:0] {
    VCSR_CLEAN,
    VCSR_DIRTY,
    VCSR_LOADING
  } vcsr_tbl_state_t;
endpackage

/* test/tb_top.sv */
// testbench for the vc status and capability registers
// assumes vcsr_regs and vcsr_chk are compiled before it
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // stimulus and checks
  // ----
  logic        mclk, srst, ce, cfg_rd, cfg_wr, cfg_rvalid, refresh_start;
  logic        negotiation_in_progress, arb_table_write;
  logic        table_load_req, refresh_done;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata;
  int          mismatches, total_checks;
  vcsr_regs vcsr_regs_i (.mclk, .srst, .ce, .cfg_rd, .cfg_wr, .cfg_addr,
    .cfg_wdata, .negotiation_in_progress, .arb_table_write,
    .table_load_req, .refresh_done, .cfg_rdata, .cfg_rvalid, .refresh_start);
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge mclk);
    cfg_rd = 1'b0;
    check("rvalid", 32'h1, {31'h0, cfg_rvalid});
    check("rdata", exp, cfg_rdata);
    // idle cycle so a following read never re-raises cfg_rd in one step
    @(negedge mclk);
  endtask
  task automatic t_freeze;
    ce = 1'b0;
    cfg_addr = 12'h16C;
    cfg_rd = 1'b1;
    arb_table_write = 1'b1;
    @(negedge mclk);
    cfg_rd = 1'b0;
    arb_table_write = 1'b0;
    check("frozen rvalid", 32'h0, {31'h0, cfg_rvalid});
    ce = 1'b1;
    @(negedge mclk);
    check("rvalid after", 32'h0, {31'h0, cfg_rvalid});
    rd(12'h16A, 32'h0);
  endtask
  task automatic t_write;
    cfg_wr = 1'b1;
    cfg_wdata = 32'hFFFFFFFF;
    cfg_addr = 12'h16A;
    @(negedge mclk);
    cfg_addr = 12'h16C;
    @(negedge mclk);
    cfg_wr = 1'b0;
    rd(12'h16A, 32'h0);
    rd(12'h16C, 32'h077F0011);
    rd(12'h170, 32'h0);
  endtask
  task automatic t_dirty;
    table_load_req = 1'b1;
    @(negedge mclk);
    table_load_req = 1'b0;
    check("start", 32'h0, {31'h0, refresh_start});
    arb_table_write = 1'b1;
    @(negedge mclk);
    arb_table_write = 1'b0;
    rd(12'h16A, 32'h1);
    table_load_req = 1'b1;
    @(negedge mclk);
    table_load_req = 1'b0;
    check("start", 32'h1, {31'h0, refresh_start});
    rd(12'h16A, 32'h1);
    refresh_done = 1'b1;
    repeat (4) @(negedge mclk);
    rd(12'h16A, 32'h0);
    refresh_done = 1'b0;
  endtask
  task automatic t_pend;
    negotiation_in_progress = 1'b1;
    repeat (4) @(negedge mclk);
    rd(12'h16A, 32'h2);
    negotiation_in_progress = 1'b0;
    repeat (4) @(negedge mclk);
    rd(12'h16A, 32'h0);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // generous bound: the whole run needs about fifty cycles
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    {srst, ce} = 2'h3;
    {cfg_rd, cfg_wr, arb_table_write, table_load_req} = 4'h0;
    {refresh_done, negotiation_in_progress} = 2'h0;
    cfg_addr = 12'h0;
    cfg_wdata = 32'h0;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    rd(12'h16A, 32'h0);
    rd(12'h16C, 32'h077F0011);
    t_write;
    t_dirty;
    t_pend;
    t_freeze;
    end_sim;
  end
endmodule
bind vcsr_regs vcsr_chk #(.ADDR_W(ADDR_W)) vcsr_chk_i (.mclk, .srst, .ce,
  .cfg_rd, .cfg_addr, .negotiation_in_progress, .arb_table_write,
  .table_load_req, .cfg_rdata, .cfg_rvalid, .refresh_start);

/* test/vcsr_regs_checker.sv */
// checker for the vc status and capability registers
// assumes it is bound onto vcsr_regs and sees only its ports
module vcsr_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic              cfg_rd,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic              negotiation_in_progress,
  input wire logic              arb_table_write,
  input wire logic              table_load_req,
  input wire logic [31:0]       cfg_rdata,
  input wire logic              cfg_rvalid,
  input wire logic              refresh_start
);
  // ----
  // checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_st;
    ce && cfg_rd && cfg_addr == 12'h16A;
  endsequence
  sequence s_cap;
    ce && cfg_rd && cfg_addr == 12'h16C;
  endsequence
  chk_rd_answer: assert property (ce && cfg_rd |=> cfg_rvalid)
    else $error("read not answered");
  chk_no_stray: assert property (ce && !cfg_rd |=> !cfg_rvalid)
    else $error("stray read valid");
  chk_cap_fixed: assert property (s_cap |=> cfg_rdata == 32'h077F0011)
    else $error("capability value wrong");
  chk_st_upper: assert property (s_st |=> cfg_rdata[31:2] == 30'h0)
    else $error("status upper bits set");
  chk_dirty_set: assert property (ce && arb_table_write ##1 s_st |=> cfg_rdata[0])
    else $error("dirty flag missing");
  // synchroniser plus pend_r register is three edges, so four high cycles is safe
  chk_pend_seen: assert property ((ce && negotiation_in_progress)[*4] ##0 s_st |=> cfg_rdata[1])
    else $error("pending flag missing");
  chk_start_cause: assert property (refresh_start && $past(ce) |-> $past(table_load_req))
    else $error("refresh start without request");
  chk_start_pulse: assert property (ce && refresh_start |=> !refresh_start)
    else $error("refresh start too long");
endmodule
